// [verilog/boot_strap_and_phy_status.sv]
// start-up strap sampling, boot selection, activity pins and clock division
`timescale 1ns/1ps
module boot_strap_and_phy_status #(
   parameter int unsigned STARTUP_CYCLES = boot_strap_pkg::STARTUP_CYCLES,
   parameter int unsigned SLOT_COUNT_W   = boot_strap_pkg::SLOT_COUNT_W,
   parameter int unsigned SLOT_LEN_W     = boot_strap_pkg::SLOT_LEN_W
) (
   input  wire logic                    clock,
   input  wire logic                    sys_rst,
   input  wire logic                    clk_en,
   input  wire logic                    soft_reset,
   input  wire logic                    physical_layer_clock,
   input  wire logic                    host_select_strap,
   input  wire logic                    boot_source_strap_pin_in,
   input  wire logic                    boot_sector_strap,
   input  wire logic                    modem_transmitting,
   input  wire logic                    modem_active_rx,
   input  wire logic                    band_rssi_busy,
   input  wire logic                    band_traffic_busy,
   input  wire logic                    biu_detect_enable,
   input  wire logic                    biu_signal_enable,
   input  wire logic                    biu_source_sel,
   input  wire logic [SLOT_COUNT_W-1:0] slot_count,
   input  wire logic [SLOT_LEN_W-1:0]   slot_length,
   input  wire logic [SLOT_COUNT_W-1:0] backoff_slots,
   input  wire logic                    tx_request,
   input  wire logic                    bootloader_done,
   output logic                         tx_grant,
   output logic                         boot_source_strap_pin_out,
   output logic                         boot_source_strap_pin_oe_n,
   output logic                         band_occupied_pin,
   output logic                         transmit_indicator_n,
   output logic                         host_is_i2c,
   output logic                         boot_from_flash,
   output logic                         boot_sector_sel,
   output logic                         bootloader_run,
   output logic                         startup_done,
   output logic                         protocol_clock_en
);
   boot_strap_pkg::phase_t phase_reg, phase_next;
   logic [31:0] count_reg, count_next;
   logic        host_reg, boot_reg, sector_reg;
   logic        act_reg, tx_ind_reg, band_pin_reg, boot_pin_reg, boot_oe_n_reg;
   logic [boot_strap_pkg::DIV_W-1:0] div_reg;

   wire sampling = (phase_reg == boot_strap_pkg::ST_SAMPLE);
   wire running  = (phase_reg == boot_strap_pkg::ST_RUN);
   wire count_end = (count_reg >= STARTUP_CYCLES - 1);
   wire band_busy = (biu_source_sel == boot_strap_pkg::BIU_SRC_TRAFFIC) ?
                    band_traffic_busy : band_rssi_busy;
   wire biu_event = biu_detect_enable && biu_signal_enable && band_busy;
   wire activity  = (modem_transmitting || modem_active_rx) ?
                    boot_strap_pkg::ACT_BUSY_LVL : boot_strap_pkg::ACT_PASSIVE_LVL;
   wire tx_level  = modem_transmitting ?
                    boot_strap_pkg::TX_ACTIVE_LVL : boot_strap_pkg::TX_IDLE_LVL;
   wire act_shown = running ? activity : boot_strap_pkg::ACT_PASSIVE_LVL;
   wire tx_shown  = running ? tx_level : boot_strap_pkg::TX_IDLE_LVL;
   wire act_on_boot = (host_reg == boot_strap_pkg::HOST_I2C);
   wire band_level  = act_on_boot ? biu_event : (act_shown & ~biu_event);
   wire sector_eff  = (boot_reg == boot_strap_pkg::BOOT_FLASH) && sector_reg;

   // sample, then run bootloader while the start-up time counts out; run once both are done
   always_comb begin
      phase_next = phase_reg;
      count_next = count_reg + 32'h1;
      unique case (phase_reg)
         boot_strap_pkg::ST_SAMPLE: phase_next = boot_strap_pkg::ST_BOOT;
         boot_strap_pkg::ST_BOOT:
            if (count_end && bootloader_done) phase_next = boot_strap_pkg::ST_RUN;
         boot_strap_pkg::ST_RUN: count_next = count_reg;
         default: phase_next = boot_strap_pkg::ST_SAMPLE;
      endcase
      if (count_end) count_next = count_reg;
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         phase_reg <= boot_strap_pkg::ST_SAMPLE;
         count_reg <= 32'h0;
      end else if (clk_en) begin
         if (soft_reset) begin
            phase_reg <= boot_strap_pkg::ST_SAMPLE;
            count_reg <= 32'h0;
         end else begin
            phase_reg <= phase_next;
            count_reg <= count_next;
         end
      end
   end

   // straps caught once per reset, then held
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         host_reg   <= boot_strap_pkg::HOST_UART;
         boot_reg   <= boot_strap_pkg::BOOT_ROM;
         sector_reg <= 1'b0;
      end else if (clk_en && sampling && !soft_reset) begin
         host_reg   <= host_select_strap;
         boot_reg   <= boot_source_strap_pin_in;
         sector_reg <= boot_sector_strap;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         tx_ind_reg    <= boot_strap_pkg::TX_IDLE_LVL;
         band_pin_reg  <= boot_strap_pkg::ACT_PASSIVE_LVL;
         boot_pin_reg  <= boot_strap_pkg::ACT_PASSIVE_LVL;
         boot_oe_n_reg <= 1'b1;
      end else if (clk_en && soft_reset) begin
         tx_ind_reg    <= boot_strap_pkg::TX_IDLE_LVL;
         band_pin_reg  <= boot_strap_pkg::ACT_PASSIVE_LVL;
         boot_pin_reg  <= boot_strap_pkg::ACT_PASSIVE_LVL;
         boot_oe_n_reg <= 1'b1;
      end else if (clk_en) begin
         tx_ind_reg    <= tx_shown;
         band_pin_reg  <= band_level;
         boot_pin_reg  <= act_shown;
         boot_oe_n_reg <= !(running && act_on_boot);
      end
   end

   // protocol clock enable: every second physical-layer tick
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) div_reg <= '0;
      else if (clk_en && physical_layer_clock) div_reg <= div_reg ^ 1'b1;
   end

   csma_access #(
      .SLOT_COUNT_W (SLOT_COUNT_W),
      .SLOT_LEN_W   (SLOT_LEN_W)
   ) u_csma (
      .clock         (clock),
      .sys_rst       (sys_rst),
      .clk_en        (clk_en),
      .enable        (running),
      .tx_request    (tx_request),
      .band_busy     (band_busy),
      .slot_count    (slot_count),
      .slot_length   (slot_length),
      .backoff_slots (backoff_slots),
      .tx_grant      (tx_grant)
   );

   assign boot_source_strap_pin_out  = boot_pin_reg;
   assign boot_source_strap_pin_oe_n = boot_oe_n_reg;
   assign band_occupied_pin          = band_pin_reg;
   assign transmit_indicator_n       = tx_ind_reg;
   assign host_is_i2c                = host_reg;
   assign boot_from_flash            = boot_reg;
   assign boot_sector_sel            = sector_eff;
   assign bootloader_run             = (phase_reg == boot_strap_pkg::ST_BOOT);
   assign startup_done               = running;
   assign protocol_clock_en          = physical_layer_clock && div_reg[0];
   assign act_reg                    = act_shown;
endmodule : boot_strap_and_phy_status

// [verilog/boot_strap_pkg.sv]
// constants for strap sampling, activity signalling and channel access
package boot_strap_pkg;
   localparam int unsigned CLOCK_HZ          = 50_000_000;
   localparam int unsigned STARTUP_TIME_MS   = 60;
   localparam int unsigned STARTUP_CYCLES    = (CLOCK_HZ / 1000) * STARTUP_TIME_MS;
   localparam int unsigned RESET_MIN_TIME_US = 1;
   localparam int unsigned RESET_MIN_CYCLES  = (CLOCK_HZ / 1_000_000) * RESET_MIN_TIME_US;
   localparam int unsigned REF_CLOCK_HZ      = 8_000_000;
   localparam logic        HOST_UART         = 1'b0;
   localparam logic        HOST_I2C          = 1'b1;
   localparam logic        BOOT_ROM          = 1'b0;
   localparam logic        BOOT_FLASH        = 1'b1;
   localparam logic        TX_ACTIVE_LVL     = 1'b0;
   localparam logic        TX_IDLE_LVL       = 1'b1;
   localparam logic        ACT_PASSIVE_LVL   = 1'b1;
   localparam logic        ACT_BUSY_LVL      = 1'b0;
   localparam logic        BIU_SRC_RSSI      = 1'b0;
   localparam logic        BIU_SRC_TRAFFIC   = 1'b1;
   localparam int unsigned SLOT_COUNT_W      = 8;
   localparam int unsigned SLOT_LEN_W        = 16;
   localparam int unsigned DIV_W             = 1;
   localparam logic [SLOT_COUNT_W-1:0] SLOT_ZERO = 8'h00;
   localparam logic [SLOT_LEN_W-1:0]   LEN_ZERO  = 16'h0000;
   typedef enum logic [2:0] {
      ST_SAMPLE = 3'b000,
      ST_BOOT   = 3'b001,
      ST_RUN    = 3'b010
   } phase_t;
   typedef enum logic [1:0] {
      CS_IDLE  = 2'b00,
      CS_SLOT  = 2'b01,
      CS_GRANT = 2'b10
   } csma_t;
endpackage : boot_strap_pkg

// [verilog/csma_access.sv]
// carrier-sense slotted channel access for the 125-140 khz band
`timescale 1ns/1ps
module csma_access #(
   parameter int unsigned SLOT_COUNT_W = boot_strap_pkg::SLOT_COUNT_W,
   parameter int unsigned SLOT_LEN_W   = boot_strap_pkg::SLOT_LEN_W
) (
   input  wire logic                    clock,
   input  wire logic                    sys_rst,
   input  wire logic                    clk_en,
   input  wire logic                    enable,
   input  wire logic                    tx_request,
   input  wire logic                    band_busy,
   input  wire logic [SLOT_COUNT_W-1:0] slot_count,
   input  wire logic [SLOT_LEN_W-1:0]   slot_length,
   input  wire logic [SLOT_COUNT_W-1:0] backoff_slots,
   output logic                         tx_grant
);
   boot_strap_pkg::csma_t state_reg, state_next;
   logic [SLOT_COUNT_W-1:0] slot_reg, slot_next;
   logic [SLOT_LEN_W-1:0]   tick_reg, tick_next;
   wire slot_done = (tick_reg == slot_length) || (slot_length == boot_strap_pkg::LEN_ZERO);
   wire last_slot = (slot_reg >= backoff_slots) || (slot_reg >= slot_count);

   // waits the chosen slots with the band free, restarts when busy
   always_comb begin
      state_next = state_reg;
      slot_next  = slot_reg;
      tick_next  = tick_reg;
      unique case (state_reg)
         boot_strap_pkg::CS_IDLE: begin
            slot_next = boot_strap_pkg::SLOT_ZERO;
            tick_next = boot_strap_pkg::LEN_ZERO;
            if (enable && tx_request) state_next = boot_strap_pkg::CS_SLOT;
         end
         boot_strap_pkg::CS_SLOT: begin
            if (!tx_request) state_next = boot_strap_pkg::CS_IDLE;
            else if (band_busy) begin
               slot_next = boot_strap_pkg::SLOT_ZERO;
               tick_next = boot_strap_pkg::LEN_ZERO;
            end else if (slot_done) begin
               tick_next = boot_strap_pkg::LEN_ZERO;
               if (last_slot) state_next = boot_strap_pkg::CS_GRANT;
               else slot_next = slot_reg + 1'b1;
            end else tick_next = tick_reg + 1'b1;
         end
         boot_strap_pkg::CS_GRANT: begin
            if (!tx_request) state_next = boot_strap_pkg::CS_IDLE;
         end
         default: state_next = boot_strap_pkg::CS_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= boot_strap_pkg::CS_IDLE;
         slot_reg  <= boot_strap_pkg::SLOT_ZERO;
         tick_reg  <= boot_strap_pkg::LEN_ZERO;
      end else if (clk_en) begin
         state_reg <= state_next;
         slot_reg  <= slot_next;
         tick_reg  <= tick_next;
      end
   end

   assign tx_grant = (state_reg == boot_strap_pkg::CS_GRANT);
endmodule : csma_access

// [sim/boot_strap_and_phy_status_properties.sv]
// checker for strap sampling and status pins
`timescale 1ns/1ps
module boot_strap_and_phy_status_properties #(
   parameter int unsigned STARTUP_CYCLES = 20
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic soft_reset,
   input wire logic host_select_strap,
   input wire logic boot_source_strap_pin_in,
   input wire logic modem_transmitting,
   input wire logic modem_active_rx,
   input wire logic biu_signal_enable,
   input wire logic boot_source_strap_pin_out,
   input wire logic boot_source_strap_pin_oe_n,
   input wire logic band_occupied_pin,
   input wire logic transmit_indicator_n,
   input wire logic host_is_i2c,
   input wire logic boot_from_flash,
   input wire logic boot_sector_sel,
   input wire logic bootloader_run,
   input wire logic startup_done
);
   logic [31:0] wait_reg;
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   // cycles spent before start-up completes
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) wait_reg <= 32'h0;
      else if (soft_reset) wait_reg <= 32'h0;
      else if (!startup_done) wait_reg <= wait_reg + 32'h1;
   end
   a_strap_capture: assert property ($rose(bootloader_run) |-> host_is_i2c == $past(host_select_strap) &&
      boot_from_flash == $past(boot_source_strap_pin_in)) else $error("straps not captured");
   a_sector_ignored: assert property (!boot_from_flash |-> !boot_sector_sel)
      else $error("sector used in rom boot");
   a_select_hold: assert property ($past(startup_done) && !$past(soft_reset) |-> $stable(host_is_i2c) && $stable(boot_from_flash))
      else $error("selection changed while running");
   a_idle_startup: assert property (!startup_done |-> transmit_indicator_n && boot_source_strap_pin_oe_n)
      else $error("indicator active before start-up");
   a_tx_follow: assert property ($past(startup_done) && !$past(soft_reset) |-> transmit_indicator_n == !$past(modem_transmitting))
      else $error("transmit indicator wrong");
   a_act_uart: assert property ($past(startup_done) && !$past(soft_reset) && !host_is_i2c && !$past(biu_signal_enable)
      |-> band_occupied_pin == !($past(modem_transmitting) || $past(modem_active_rx))) else $error("band pin activity wrong");
   a_act_i2c: assert property ($past(startup_done) && !$past(soft_reset) && host_is_i2c |-> !boot_source_strap_pin_oe_n &&
      boot_source_strap_pin_out == !($past(modem_transmitting) || $past(modem_active_rx))) else $error("boot pin activity wrong");
   a_boot_first: assert property ($rose(startup_done) |-> $past(bootloader_run) && wait_reg >= STARTUP_CYCLES)
      else $error("start-up too early");
endmodule : boot_strap_and_phy_status_properties
bind boot_strap_and_phy_status boot_strap_and_phy_status_properties #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_props (
   .clock, .sys_rst, .soft_reset, .host_select_strap, .boot_source_strap_pin_in, .modem_transmitting,
   .modem_active_rx, .biu_signal_enable, .boot_source_strap_pin_out, .boot_source_strap_pin_oe_n,
   .band_occupied_pin, .transmit_indicator_n, .host_is_i2c, .boot_from_flash, .boot_sector_sel,
   .bootloader_run, .startup_done);

// [sim/strap_board_model.sv]
// board straps and bootloader completion model around the block
`timescale 1ns/1ps
module strap_board_model (
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic [2:0] strap_lvl,
   input  wire logic       pin_out,
   input  wire logic       pin_oe_n,
   input  wire logic       boot_run,
   output logic            host_sel,
   output logic            boot_pin,
   output logic            sector,
   output logic            boot_done
);
   logic [2:0] boot_reg;
   assign host_sel  = strap_lvl[2];
   assign boot_pin  = pin_oe_n ? strap_lvl[1] : pin_out; // strap resistor wins when released
   assign sector    = strap_lvl[0];
   assign boot_done = (boot_reg == 3'h5);
   // bootloader finishes a few cycles into the boot phase
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst || !boot_run) boot_reg <= 3'h0;
      else if (!boot_done) boot_reg <= boot_reg + 3'h1;
   end
endmodule : strap_board_model

// [sim/test_boot_strap_and_phy_status.sv]
// self-checking bench for the strap and status block
`timescale 1ns/1ps
module test_boot_strap_and_phy_status;
   logic clock, sys_rst, soft_reset, phy_clk, tx_on, rx_on, rssi, det_en, sig_en, src_sel, want_tx;
   logic [2:0] straps;
   logic [7:0] slots, backoff;
   logic [15:0] slot_len;
   logic grant, pin_out, oe_n, band_pin, tx_n, i2c, flash, sector_sel, boot_run, done, proto_en;
   wire host_sel, boot_pin, sector, boot_done;
   int bad_count, n_tests;
   boot_strap_and_phy_status #(.STARTUP_CYCLES(20)) u_boot_strap_and_phy_status (.clock(clock),
      .sys_rst(sys_rst), .clk_en(1'b1), .soft_reset(soft_reset), .physical_layer_clock(phy_clk),
      .host_select_strap(host_sel), .boot_source_strap_pin_in(boot_pin), .boot_sector_strap(sector),
      .modem_transmitting(tx_on), .modem_active_rx(rx_on), .band_rssi_busy(rssi), .band_traffic_busy(1'b0),
      .biu_detect_enable(det_en), .biu_signal_enable(sig_en), .biu_source_sel(src_sel), .slot_count(slots),
      .slot_length(slot_len), .backoff_slots(backoff), .tx_request(want_tx & done), .bootloader_done(boot_done),
      .tx_grant(grant), .boot_source_strap_pin_out(pin_out), .boot_source_strap_pin_oe_n(oe_n),
      .band_occupied_pin(band_pin), .transmit_indicator_n(tx_n), .host_is_i2c(i2c), .boot_from_flash(flash),
      .boot_sector_sel(sector_sel), .bootloader_run(boot_run), .startup_done(done), .protocol_clock_en(proto_en));
   strap_board_model u_strap_board_model (.clock(clock), .sys_rst(sys_rst), .strap_lvl(straps), .pin_out(pin_out),
      .pin_oe_n(oe_n), .boot_run(boot_run), .host_sel(host_sel), .boot_pin(boot_pin), .sector(sector),
      .boot_done(boot_done));
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: %s", $time, what);
      end
   endtask : check
   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   task automatic restart;
      soft_reset = 1'b1;
      tick(1);
      soft_reset = 1'b0;
      for (int i = 0; i < 80 && done !== 1'b1; i++) tick(1);
      check(done, 1'b1, "start-up");
   endtask : restart
   task automatic t_straps;
      for (int s = 0; s < 8; s++) begin
         straps = s[2:0];
         restart();
         check(i2c, s[2], "host port");
         check(flash, s[1], "boot source");
         check(sector_sel, s[1] & s[0], "boot sector");
         straps = ~straps;
         tick(3);
         check({i2c, flash}, s[2:1], "selection held");
         for (int m = 0; m < 4; m++) begin
            {tx_on, rx_on} = m[1:0];
            tick(2);
            check(tx_n, !m[1], "tx indicator");
            check(s[2] ? boot_pin : band_pin, !(m[1] | m[0]), "activity");
         end
      end
      straps = 3'h0;
      restart();
   endtask : t_straps
   task automatic t_band_csma;
      {det_en, sig_en, rssi} = 3'h7;
      tick(3);
      check(band_pin, 1'b0, "band in use shown");
      sig_en = 1'b0;
      want_tx = 1'b1;
      tick(40);
      check(grant, 1'b0, "grant on busy band");
      src_sel = 1'b1;
      tick(4);
      check(grant, 1'b0, "grant before slots");
      tick(8);
      check(grant, 1'b1, "grant after slots");
      want_tx = 1'b0;
      tick(2);
      check(grant, 1'b0, "grant released");
   endtask : t_band_csma
   task automatic t_clock;
      logic [7:0] n;
      n = 8'h00;
      phy_clk = 1'b1;
      for (int i = 0; i < 8; i++) begin
         n = n + {7'h00, proto_en};
         tick(1);
      end
      phy_clk = 1'b0;
      check(n, 8'h04, "protocol clock");
   endtask : t_clock
   initial begin
      {soft_reset, phy_clk, tx_on, rx_on, rssi, det_en, sig_en, src_sel, want_tx} = 9'h000;
      {straps, slots, backoff, slot_len} = {3'h0, 8'h04, 8'h01, 16'h0003};
      sys_rst = 1'b1;
      bad_count = 0;
      n_tests = 0;
      tick(8);
      check({tx_n, oe_n}, 2'h3, "idle in reset");
      tick(8);
      sys_rst = 1'b0;
      t_straps();
      t_band_csma();
      t_clock();
      summarize();
   end
   initial begin
      #100000;
      bad_count++;
      summarize();
   end
endmodule : test_boot_strap_and_phy_status
